/* File: design/pievx_pkg.sv */
// shared constants and types for the prioritised interrupt and event transfer block
package pievx_pkg;
    localparam int NUM_SRC = 16;            // interrupt nodes handled
    localparam int NUM_CH = 8;              // event transfer channels
    localparam int NUM_EXT = 8;             // fast external inputs
    localparam int PRIO_W = 4;              // sixteen levels
    localparam int TRAP_W = 7;
    localparam int VEC_W = 24;
    localparam int CNT_W = 8;
    localparam int ADDR_W = 24;
    localparam int CH_W = 3;
    localparam int SRC_W = 4;
    // trap number of external input 0, later inputs follow by one
    localparam logic [TRAP_W-1:0] EXT_TRAP_BASE = 7'h18;
    // vector stride is four bytes: shift the trap number by two
    localparam int VEC_SHIFT = 2;
    // response window in cpu clocks
    localparam int RESP_MIN = 5;
    localparam int RESP_MAX = 12;
    // delay from entering the wait state to service start, inside the window
    localparam logic [3:0] RESP_DLY = 4'h5;
    // edge select encodings
    localparam logic [1:0] EDGE_OFF = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // no service running
    localparam logic [PRIO_W:0] IDLE_LEVEL = 5'h00;

    typedef enum logic [1:0]
    {
        PIEVX_IDLE = 2'b00,
        PIEVX_WAIT = 2'b01,
        PIEVX_XFER = 2'b10,
        PIEVX_VECT = 2'b11
    } pievx_state_t;
endpackage

/* File: design/pievx_edge.sv */
// synchroniser and programmable edge detector for one fast external input
`timescale 1ns/10ps
module pievx_edge
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // pin and mode
    input wire logic pin_in,
    input wire logic [1:0] edge_sel,
    // detected edge
    output logic edge_pulse
);
    typedef struct packed
    {
        logic s1;
        logic s2;
        logic s3;
        logic pulse;
    } pievx_edge_st_t;

    pievx_edge_st_t st_reg;
    pievx_edge_st_t st_next;

    // three-stage sync, edge when stages two and three differ
    always_comb
    begin
        st_next = st_reg;
        st_next.s1 = pin_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        st_next.pulse = 1'b0;
        case (edge_sel)
            pievx_pkg::EDGE_RISE: st_next.pulse = st_reg.s2 & ~st_reg.s3;
            pievx_pkg::EDGE_FALL: st_next.pulse = ~st_reg.s2 & st_reg.s3;
            pievx_pkg::EDGE_BOTH: st_next.pulse = st_reg.s2 ^ st_reg.s3;
            default: st_next.pulse = 1'b0;
        endcase
    end

    // state register
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            st_reg <= '0;
        else if (clk_en)
            st_reg <= st_next;
    end

    assign edge_pulse = st_reg.pulse;
endmodule

/* File: design/pievx_arb.sv */
// priority arbiter: picks highest enabled pending node
`timescale 1ns/10ps
module pievx_arb
#(
    parameter int NSRC = 16
)
(
    // request vectors
    input wire logic [NSRC-1:0] pend,
    input wire logic [NSRC*pievx_pkg::PRIO_W-1:0] prio,
    // winner
    output logic win_valid,
    output logic [pievx_pkg::SRC_W-1:0] win_idx,
    output logic [pievx_pkg::PRIO_W-1:0] win_prio
);
    // linear scan, higher level wins, lower index wins a tie
    always_comb
    begin
        win_valid = 1'b0;
        win_idx = '0;
        win_prio = '0;
        for (int i = 0; i < NSRC; i++)
        begin
            if (pend[i] && (!win_valid
                || prio[i*pievx_pkg::PRIO_W +: pievx_pkg::PRIO_W] > win_prio))
            begin
                win_valid = 1'b1;
                win_idx = pievx_pkg::SRC_W'(i);
                win_prio = prio[i*pievx_pkg::PRIO_W +: pievx_pkg::PRIO_W];
            end
        end
    end
endmodule

/* File: design/pievx_top.sv */
// prioritised interrupt controller with event transfer channels
// Notes on behaviour
// - service starts 5 to 12 clocks after request
// - each node routed to vector or channel
// - channel transfer steals exactly one cycle
// - move byte or word, bump one pointer
// - count decrements unless continuous mode
// - count zero raises owner's vectored interrupt
// - eight independent event transfer channels
// - per node request, enable, priority bits
// - priority field selects sixteen levels
// - only strictly higher priority preempts
// - vector dedicated to each requesting node
// - fast inputs detect rise, fall, both
// - trap instruction enters numbered vector
// - software-set request acts like hardware
// - external inputs trap 18h upward, 60h..7Ch
`timescale 1ns/10ps
module pievx_top
#(
    parameter int NSRC = pievx_pkg::NUM_SRC,
    parameter int NCH = pievx_pkg::NUM_CH,
    parameter int NEXT = pievx_pkg::NUM_EXT
)
(
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // peripheral request pulses and fast pins
    input wire logic [NSRC-1:0] periph_req,
    input wire logic [NEXT-1:0] ext_pin,
    input wire logic [NEXT*2-1:0] ext_edge_sel,
    // node control written by software
    input wire logic [NSRC-1:0] node_set_req,
    input wire logic [NSRC-1:0] node_clr_req,
    input wire logic [NSRC-1:0] node_enable,
    input wire logic [NSRC*pievx_pkg::PRIO_W-1:0] node_prio,
    input wire logic [NSRC-1:0] node_use_channel,
    input wire logic [NSRC*pievx_pkg::CH_W-1:0] node_channel,
    input wire logic [NSRC*pievx_pkg::TRAP_W-1:0] node_trap,
    // channel setup
    input wire logic [NCH-1:0] ch_load,
    input wire logic [NCH*pievx_pkg::ADDR_W-1:0] ch_src_init,
    input wire logic [NCH*pievx_pkg::ADDR_W-1:0] ch_dst_init,
    input wire logic [NCH*pievx_pkg::CNT_W-1:0] ch_cnt_init,
    input wire logic [NCH-1:0] ch_byte_mode,
    input wire logic [NCH-1:0] ch_inc_dst,
    input wire logic [NCH-1:0] ch_continuous,
    // cpu handshake
    input wire logic cpu_ack,
    input wire logic cpu_return,
    input wire logic trap_valid,
    input wire logic [pievx_pkg::TRAP_W-1:0] trap_num,
    // vectored interrupt request to cpu
    output logic int_req,
    output logic [pievx_pkg::VEC_W-1:0] int_vector,
    output logic [pievx_pkg::TRAP_W-1:0] int_trap,
    output logic [pievx_pkg::PRIO_W:0] run_level,
    // event transfer cycle
    output logic xfer_valid,
    output logic [pievx_pkg::ADDR_W-1:0] xfer_src,
    output logic [pievx_pkg::ADDR_W-1:0] xfer_dst,
    output logic xfer_byte,
    // status
    output logic [NSRC-1:0] node_request_bit,
    output logic [NCH*pievx_pkg::CNT_W-1:0] ch_count
);
    localparam int AW = pievx_pkg::ADDR_W;
    localparam int CW = pievx_pkg::CNT_W;
    localparam int PW = pievx_pkg::PRIO_W;
    localparam int TW = pievx_pkg::TRAP_W;
    localparam int HW = pievx_pkg::CH_W;

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_reg;
    logic rst_n;

    // two-stage release of the asynchronous reset
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            rst_sync_reg <= 2'b00;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    assign rst_n = rst_sync_reg[1];

    // ----------------------------------------------------------------
    // fast external inputs
    // ----------------------------------------------------------------
    logic [NSRC-1:0] hw_req;
    logic [NEXT-1:0] ext_edge;

    genvar g;
    generate
        for (g = 0; g < NSRC; g++)
        begin : gen_src
            if (g < NEXT)
            begin : gen_ext
                pievx_edge u_edge
                (
                    .ref_clk(ref_clk),
                    .rst_n(rst_n),
                    .clk_en(clk_en),
                    .pin_in(ext_pin[g]),
                    .edge_sel(ext_edge_sel[g*2 +: 2]),
                    .edge_pulse(ext_edge[g])
                );
                assign hw_req[g] = ext_edge[g] | periph_req[g];
            end
            else
            begin : gen_per
                assign hw_req[g] = periph_req[g];
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed
    {
        pievx_pkg::pievx_state_t state;
        logic [NSRC-1:0] req;
        logic [3:0] dly;
        logic [pievx_pkg::SRC_W-1:0] sel;
        logic trap_pend;
        logic [TW-1:0] trap_id;
        logic [PW:0] level;
        logic [NSRC:0][PW:0] lvl_stk;
        logic is_trap;
        logic irq;
        logic [pievx_pkg::VEC_W-1:0] vec;
        logic [TW-1:0] trap_out;
        logic xv;
        logic [AW-1:0] xsrc;
        logic [AW-1:0] xdst;
        logic xbyte;
        logic [NCH*AW-1:0] src_ptr;
        logic [NCH*AW-1:0] dst_ptr;
        logic [NCH*CW-1:0] cnt;
        logic [NSRC-1:0] force_vec;
    } pievx_st_t;

    pievx_st_t st_reg;
    pievx_st_t st_next;

    // ----------------------------------------------------------------
    // arbitration
    // ----------------------------------------------------------------
    logic win_valid;
    logic [pievx_pkg::SRC_W-1:0] win_idx;
    logic [PW-1:0] win_prio;
    logic [NSRC-1:0] pend;

    assign pend = st_reg.req & node_enable;

    pievx_arb #(.NSRC(NSRC)) u_arb
    (
        .pend(pend),
        .prio(node_prio),
        .win_valid(win_valid),
        .win_idx(win_idx),
        .win_prio(win_prio)
    );

    // channel, priority and trap number of the selected node
    logic [HW-1:0] sel_ch;
    logic [PW-1:0] sel_prio;
    logic [TW-1:0] sel_trap;
    assign sel_ch = node_channel[st_reg.sel*HW +: HW];
    assign sel_prio = node_prio[st_reg.sel*PW +: PW];
    assign sel_trap = node_trap[st_reg.sel*TW +: TW];

    // trap number of a node: external inputs fixed, others programmed
    function automatic logic [TW-1:0] node_trap_of(input logic [pievx_pkg::SRC_W-1:0] n,
                                                  input logic [TW-1:0] prog);
        logic [TW-1:0] t;
        t = prog;
        if (int'(n) < NEXT)
            t = pievx_pkg::EXT_TRAP_BASE + TW'(n);
        return t;
    endfunction

    function automatic logic [pievx_pkg::VEC_W-1:0] vec_of(input logic [TW-1:0] t);
        return pievx_pkg::VEC_W'(t) << pievx_pkg::VEC_SHIFT;
    endfunction

    // ----------------------------------------------------------------
    // controller
    // ----------------------------------------------------------------
    always_comb
    begin
        logic [HW-1:0] ch;
        logic [AW-1:0] step;
        logic [CW-1:0] c;
        ch = sel_ch;
        step = '0;
        c = '0;
        st_next = st_reg;
        st_next.xv = 1'b0;

        // software set behaves like hardware request
        st_next.req = (st_reg.req & ~node_clr_req) | node_set_req | hw_req;

        for (int i = 0; i < NCH; i++)
        begin
            if (ch_load[i])
            begin
                st_next.src_ptr[i*AW +: AW] = ch_src_init[i*AW +: AW];
                st_next.dst_ptr[i*AW +: AW] = ch_dst_init[i*AW +: AW];
                st_next.cnt[i*CW +: CW] = ch_cnt_init[i*CW +: CW];
            end
        end

        // return from service pops the previous level, empty stack gives idle
        if (cpu_return)
        begin
            st_next.level = st_reg.lvl_stk[0];
            st_next.lvl_stk = {pievx_pkg::IDLE_LEVEL, st_reg.lvl_stk[NSRC:1]};
        end

        if (trap_valid)
        begin
            st_next.trap_pend = 1'b1;
            st_next.trap_id = trap_num;
        end

        case (st_reg.state)
            pievx_pkg::PIEVX_IDLE:
            begin
                if (st_reg.trap_pend)
                begin
                    st_next.state = pievx_pkg::PIEVX_VECT;
                    st_next.irq = 1'b1;
                    st_next.vec = vec_of(st_reg.trap_id);
                    st_next.trap_out = st_reg.trap_id;
                    st_next.is_trap = 1'b1;
                    st_next.trap_pend = trap_valid;
                end
                else if (win_valid && {1'b1, win_prio} > st_reg.level)
                begin
                    st_next.state = pievx_pkg::PIEVX_WAIT;
                    st_next.sel = win_idx;
                    st_next.dly = pievx_pkg::RESP_DLY;
                end
            end
            pievx_pkg::PIEVX_WAIT:
            begin
                st_next.dly = st_reg.dly - 4'h1;
                if (st_reg.dly == 4'h1)
                begin
                    st_next.req[st_reg.sel] = node_set_req[st_reg.sel] | hw_req[st_reg.sel];
                    if (node_use_channel[st_reg.sel] && !st_reg.force_vec[st_reg.sel])
                    begin
                        st_next.state = pievx_pkg::PIEVX_XFER;
                        st_next.xv = 1'b1;
                        st_next.xsrc = st_reg.src_ptr[ch*AW +: AW];
                        st_next.xdst = st_reg.dst_ptr[ch*AW +: AW];
                        st_next.xbyte = ch_byte_mode[ch];
                        step = ch_byte_mode[ch] ? AW'(1) : AW'(2);
                        if (ch_inc_dst[ch])
                            st_next.dst_ptr[ch*AW +: AW] = st_reg.dst_ptr[ch*AW +: AW] + step;
                        else
                            st_next.src_ptr[ch*AW +: AW] = st_reg.src_ptr[ch*AW +: AW] + step;
                        c = st_reg.cnt[ch*CW +: CW];
                        if (!ch_continuous[ch])
                        begin
                            c = c - CW'(1);
                            st_next.cnt[ch*CW +: CW] = c;
                            // zero count falls back to vector
                            if (c == '0)
                            begin
                                st_next.force_vec[st_reg.sel] = 1'b1;
                                st_next.req[st_reg.sel] = 1'b1;
                            end
                        end
                    end
                    else
                    begin
                        st_next.state = pievx_pkg::PIEVX_VECT;
                        st_next.irq = 1'b1;
                        st_next.force_vec[st_reg.sel] = 1'b0;
                        st_next.is_trap = 1'b0;
                        st_next.trap_out = node_trap_of(st_reg.sel, sel_trap);
                        st_next.vec = vec_of(node_trap_of(st_reg.sel, sel_trap));
                    end
                end
            end
            pievx_pkg::PIEVX_XFER:
            begin
                st_next.state = pievx_pkg::PIEVX_IDLE;
            end
            pievx_pkg::PIEVX_VECT:
            begin
                if (cpu_ack)
                begin
                    st_next.irq = 1'b0;
                    st_next.state = pievx_pkg::PIEVX_IDLE;
                    // push the running level so nested returns unwind; traps keep it
                    st_next.lvl_stk = {st_reg.lvl_stk[NSRC-1:0], st_reg.level};
                    st_next.level = st_reg.is_trap ? st_reg.level : {1'b1, sel_prio};
                end
            end
            default:
            begin
                st_next.state = pievx_pkg::PIEVX_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            st_reg <= '{state: pievx_pkg::PIEVX_IDLE, level: pievx_pkg::IDLE_LEVEL,
                        default: '0};
        else if (clk_en)
            st_reg <= st_next;
    end

    // outputs straight from the state register
    assign int_req = st_reg.irq;
    assign int_vector = st_reg.vec;
    assign int_trap = st_reg.trap_out;
    assign run_level = st_reg.level;
    assign xfer_valid = st_reg.xv;
    assign xfer_src = st_reg.xsrc;
    assign xfer_dst = st_reg.xdst;
    assign xfer_byte = st_reg.xbyte;
    assign node_request_bit = st_reg.req;
    assign ch_count = st_reg.cnt;
endmodule

/* File: sim/pievx_checker.sv */
// concurrent checks on the ports of the interrupt and event transfer block
`timescale 1ns/10ps
module pievx_checker
#(
    parameter int NSRC = pievx_pkg::NUM_SRC
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // cpu handshake and node state
    input wire logic cpu_ack,
    input wire logic cpu_return,
    input wire logic [NSRC-1:0] node_enable,
    input wire logic [NSRC-1:0] node_request_bit,
    // service outputs
    input wire logic int_req,
    input wire logic [pievx_pkg::VEC_W-1:0] int_vector,
    input wire logic [pievx_pkg::TRAP_W-1:0] int_trap,
    input wire logic [pievx_pkg::PRIO_W:0] run_level,
    input wire logic xfer_valid
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    // a fresh enabled request while nothing runs, and the service that answers it
    sequence s_new_req;
        $rose(|(node_request_bit & node_enable)) && !run_level[4] && !int_req;
    endsequence
    sequence s_serve;
        int_req || xfer_valid;
    endsequence

    a_resp_window: assert property (s_new_req |-> ##[4:11] s_serve)
        else $error("service did not start in the response window");
    a_vector_four: assert property (int_req |-> int_vector == {int_trap, 2'b00})
        else $error("vector is not trap number times four");
    a_xfer_single: assert property (xfer_valid |=> !xfer_valid)
        else $error("transfer cycle longer than one clock");
    a_one_service: assert property (int_req |-> !xfer_valid)
        else $error("transfer during a vectored request");
    a_req_holds: assert property (int_req && !cpu_ack |=> int_req && $stable(int_vector))
        else $error("vectored request dropped or changed before accept");
    a_ack_accept: assert property (int_req && cpu_ack |=> !int_req)
        else $error("request still raised after accept");
    a_level_held: assert property (!cpu_ack && !cpu_return |=> $stable(run_level))
        else $error("running level moved without accept or return");
    a_xfer_origin: assert property (xfer_valid |-> $past(|node_request_bit))
        else $error("transfer without a pending node");
endmodule

bind pievx_top pievx_checker #(.NSRC(NSRC)) u_pievx_checker (.ref_clk, .resetn, .cpu_ack,
    .cpu_return, .node_enable, .node_request_bit, .int_req, .int_vector, .int_trap,
    .run_level, .xfer_valid);

/* File: sim/pievx_cpu_model.sv */
// behavioural cpu core that accepts and finishes vectored services
`timescale 1ns/10ps
module pievx_cpu_model
(
    // clock
    input wire logic ref_clk,
    // request and pacing
    input wire logic int_req,
    input wire logic [3:0] ack_dly,
    input wire logic ret_en,
    // handshake back
    output logic cpu_ack,
    output logic cpu_return
);
    int wait_n = 0;
    int depth_n = 0;

    initial
    begin
        cpu_ack = 1'b0;
        cpu_return = 1'b0;
    end

    // accept after ack_dly cycles; finish one nested service every other cycle when allowed
    always @(negedge ref_clk)
    begin
        cpu_ack <= 1'b0;
        cpu_return <= 1'b0;
        if (int_req === 1'b1 && !cpu_ack)
        begin
            wait_n <= wait_n + 1;
            if (wait_n >= ack_dly)
            begin
                cpu_ack <= 1'b1;
                wait_n <= 0;
                depth_n <= depth_n + 1;
            end
        end
        else if (depth_n > 0 && ret_en && !cpu_return)
        begin
            cpu_return <= 1'b1;
            depth_n <= depth_n - 1;
        end
    end
endmodule

/* File: sim/pievx_bench.sv */
// self-checking bench for the interrupt and event transfer block
`timescale 1ns/10ps
module pievx_bench;
    localparam int S = pievx_pkg::NUM_SRC;
    localparam int C = pievx_pkg::NUM_CH;
    localparam int AW = pievx_pkg::ADDR_W;
    localparam int KW = pievx_pkg::CNT_W;
    logic ref_clk = 0, resetn = 0, clk_en = 1, trap_valid = 0, ret_en = 1;
    logic cpu_ack, cpu_return, int_req, xfer_valid, xfer_byte;
    logic [3:0] ack_dly = 0;
    logic [S-1:0] periph_req = 0, node_set_req = 0, node_clr_req = 0, node_enable = 0;
    logic [S-1:0] node_use_channel = 0, node_request_bit;
    logic [pievx_pkg::NUM_EXT-1:0] ext_pin = 0;
    logic [pievx_pkg::NUM_EXT*2-1:0] ext_edge_sel = 0;
    logic [S*pievx_pkg::PRIO_W-1:0] node_prio = 0;
    logic [S*pievx_pkg::CH_W-1:0] node_channel = 0;
    logic [S*pievx_pkg::TRAP_W-1:0] node_trap = 0;
    logic [C-1:0] ch_load = 0, ch_byte_mode = 0, ch_inc_dst = 0, ch_continuous = 0;
    logic [C*AW-1:0] ch_src_init = 0, ch_dst_init = 0;
    logic [C*KW-1:0] ch_cnt_init = 0, ch_count;
    logic [pievx_pkg::TRAP_W-1:0] trap_num = 0, int_trap;
    logic [pievx_pkg::VEC_W-1:0] int_vector;
    logic [AW-1:0] xfer_src, xfer_dst;
    logic [pievx_pkg::PRIO_W:0] run_level;
    int error_cnt = 0, n_compared = 0;
    int n;

    pievx_top u_pievx_top (.ref_clk, .resetn, .clk_en, .periph_req, .ext_pin, .ext_edge_sel,
        .node_set_req, .node_clr_req, .node_enable, .node_prio, .node_use_channel,
        .node_channel, .node_trap, .ch_load, .ch_src_init, .ch_dst_init, .ch_cnt_init,
        .ch_byte_mode, .ch_inc_dst, .ch_continuous, .cpu_ack, .cpu_return, .trap_valid,
        .trap_num, .int_req, .int_vector, .int_trap, .run_level, .xfer_valid, .xfer_src,
        .xfer_dst, .xfer_byte, .node_request_bit, .ch_count);
    pievx_cpu_model u_pievx_cpu_model (.ref_clk, .int_req, .ack_dly, .ret_en, .cpu_ack,
        .cpu_return);

    // clock
    always #2.5 ref_clk = ~ref_clk;

    // compare and report
    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        if (error_cnt == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // node setup: enable, level, routing, trap number
    task automatic setn(int i, logic [3:0] p, logic use_ch, logic [2:0] ch, logic [6:0] t);
        node_enable[i] = 1'b1;
        node_prio[i*pievx_pkg::PRIO_W +: pievx_pkg::PRIO_W] = p;
        node_use_channel[i] = use_ch;
        node_channel[i*pievx_pkg::CH_W +: pievx_pkg::CH_W] = ch;
        node_trap[i*pievx_pkg::TRAP_W +: pievx_pkg::TRAP_W] = t;
    endtask

    // one-cycle request pulse on a peripheral line or a software set
    task automatic fire(int i, bit sw);
        @(negedge ref_clk);
        if (sw)
            node_set_req[i] = 1'b1;
        else
            periph_req[i] = 1'b1;
        @(negedge ref_clk);
        node_set_req[i] = 1'b0;
        periph_req[i] = 1'b0;
    endtask

    // bounded wait for a vectored request or a transfer cycle
    task automatic wait_svc;
        n = 0;
        while (int_req !== 1'b1 && xfer_valid !== 1'b1 && n < 40)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk(n < 40, 1);
    endtask

    // ends on a falling edge so that following stimulus keeps to that edge
    task automatic settle;
        repeat (20) @(negedge ref_clk);
    endtask

    // vectored path from hardware and software requests
    task automatic t_vect;
        ack_dly = 4'h6;
        setn(9, 4'h3, 1'b0, 3'h0, 7'h40);
        setn(10, 4'h3, 1'b0, 3'h0, 7'h41);
        fire(9, 0);
        wait_svc();
        chk(n >= 5 && n <= 12, 1);
        chk(int_trap, 7'h40);
        chk(int_vector, 24'h00_0100);
        settle();
        fire(10, 1);
        wait_svc();
        chk(int_vector, 24'h00_0104);
        settle();
        ack_dly = 4'h0;
    endtask

    // edge modes on fast inputs, then one serviced external node
    task automatic t_ext;
        for (int k = 0; k < 4; k++)
        begin
            ext_edge_sel[2*k +: 2] = 2'(k);
            @(negedge ref_clk) ext_pin[k] = 1'b1;
            settle();
            chk(node_request_bit[k], k == 1 || k == 3);
            @(negedge ref_clk) node_clr_req[k] = 1'b1;
            @(negedge ref_clk) node_clr_req[k] = 1'b0;
            ext_pin[k] = 1'b0;
            settle();
            chk(node_request_bit[k], k >= 2);
        end
        setn(7, 4'h5, 1'b0, 3'h0, 7'h00);
        ext_edge_sel[15:14] = pievx_pkg::EDGE_RISE;
        @(negedge ref_clk) ext_pin[7] = 1'b1;
        wait_svc();
        chk(int_trap, 7'h1F);
        chk(int_vector, 24'h00_007C);
        settle();
    endtask

    // event transfers on one channel, byte or word, with or without counting
    task automatic xfer_run(int ch, logic bm, logic idst, logic cont);
        int st;
        st = bm ? 1 : 2;
        ch_src_init[ch*AW +: AW] = 24'h00_1000;
        ch_dst_init[ch*AW +: AW] = 24'h00_2000;
        ch_cnt_init[ch*KW +: KW] = 8'h02;
        ch_byte_mode[ch] = bm;
        ch_inc_dst[ch] = idst;
        ch_continuous[ch] = cont;
        @(negedge ref_clk) ch_load[ch] = 1'b1;
        @(negedge ref_clk) ch_load[ch] = 1'b0;
        setn(2, 4'h4, 1'b1, 3'(ch), 7'h00);
        for (int j = 0; j < 2; j++)
        begin
            fire(2, 0);
            wait_svc();
            chk(xfer_valid, 1);
            chk(int_req, 0);
            chk(xfer_byte, bm);
            chk(xfer_src, 24'h00_1000 + (idst ? 0 : st * j));
            chk(xfer_dst, 24'h00_2000 + (idst ? st * j : 0));
            @(posedge ref_clk);
            #1;
            chk(xfer_valid, 0);
            chk(ch_count[ch*KW +: KW], cont ? 2 : 1 - j);
        end
        if (!cont)
        begin
            wait_svc();
            chk(int_trap, 7'h1A);
            chk(int_vector, 24'h00_0068);
        end
        settle();
        chk(node_request_bit[2], 0);
    endtask

    // equal level waits, higher level preempts
    task automatic t_prio;
        ret_en = 1'b0;
        setn(11, 4'h3, 1'b0, 3'h0, 7'h22);
        setn(12, 4'h3, 1'b0, 3'h0, 7'h23);
        setn(13, 4'hF, 1'b0, 3'h0, 7'h24);
        fire(11, 0);
        wait_svc();
        chk(int_trap, 7'h22);
        repeat (3) @(posedge ref_clk);
        #1;
        chk(run_level, 5'h13);
        fire(12, 0);
        repeat (14) @(posedge ref_clk);
        #1;
        chk(int_req, 0);
        fire(13, 0);
        wait_svc();
        chk(int_trap, 7'h24);
        repeat (3) @(posedge ref_clk);
        #1;
        chk(run_level, 5'h1F);
        ret_en = 1'b1;
        repeat (40) @(posedge ref_clk);
        #1;
        chk(run_level, 5'h00);
        chk(node_request_bit[13:11], 3'h0);
    endtask

    // trap instruction enters its numbered vector
    task automatic t_trap;
        @(negedge ref_clk);
        trap_num = 7'h2B;
        trap_valid = 1'b1;
        @(negedge ref_clk) trap_valid = 1'b0;
        wait_svc();
        chk(int_trap, 7'h2B);
        chk(int_vector, 24'h00_00AC);
        settle();
    endtask

    // watchdog against a hang
    initial
    begin
        #30000;
        error_cnt++;
        tally_and_finish();
    end

    // main sequence
    initial
    begin
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk) resetn = 1'b1;
        repeat (3) @(negedge ref_clk);
        t_vect();
        t_ext();
        xfer_run(5, 1'b1, 1'b1, 1'b0);
        xfer_run(0, 1'b0, 1'b0, 1'b1);
        t_prio();
        t_trap();
        tally_and_finish();
    end
endmodule
